//--- core/gpio_port_map.svh
// register offsets, field positions and reset values of the port register bank
// assumes byte-wide registers reached at byte offsets over a plain register port
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define DRIVE_ENABLE_OFS 8'h00
`define DRIVE_ENABLE_SET_VIEW_OFS 8'h01
`define DRIVE_ENABLE_CLEAR_VIEW_OFS 8'h02
`define DRIVE_ENABLE_FLIP_VIEW_OFS 8'h03
`define DRIVE_LEVEL_OFS 8'h04
`define DRIVE_LEVEL_SET_VIEW_OFS 8'h05
`define DRIVE_LEVEL_CLEAR_VIEW_OFS 8'h06
`define DRIVE_LEVEL_FLIP_VIEW_OFS 8'h07
`define PIN_VALUE_OFS 8'h08
`define IRQ_CONTROL_OFS 8'h09
`define IRQ0_SOURCE_SELECT_OFS 8'h0a
`define IRQ1_SOURCE_SELECT_OFS 8'h0b
`define IRQ_PENDING_FLAGS_OFS 8'h0c
// pad configuration of pin n sits at this base plus n
`define PAD_CONFIG_BASE_OFS 8'h10

`define IRQ0_LEVEL_LSB 0
`define IRQ1_LEVEL_LSB 2
`define IRQ_LEVEL_W 2
`define IRQ0_PENDING_BIT 0
`define IRQ1_PENDING_BIT 1
`define SENSE_MODE_LSB 0
`define SENSE_MODE_W 3

`define PORT_REG_RESET 8'h00
`define SENSE_MODE_RESET 3'h0

`endif

//--- core/gpio_port_pkg.sv
// types shared by the port register bank
// assumes the offsets and field positions come from gpio_port_map.svh
package gpio_port_pkg;

  typedef enum logic [2:0] {
    sense_both_edges = 3'h0,
    sense_rising = 3'h1,
    sense_falling = 3'h2,
    sense_low_level = 3'h3,
    sense_input_off = 3'h7
  } sense_mode_e;

  typedef logic [7:0] port_byte_t;
  typedef logic [1:0] irq_level_t;

endpackage

//--- core/gpio_port_register_bank.sv
// 8-bit general-purpose port: direction, output level, pin value, two pin interrupt sources
// assumes pins are synchronous to clk_sys and a plain byte-wide register port
//
// Summary of operation
// - drive-enable at offset 0: bit one makes pin output, zero input
// - writing drive-enable set view sets bits written one only
// - writing drive-enable clear view clears bits written one only
// - writing drive-enable flip view inverts bits written one only
// - reading any drive-enable view returns the drive-enable contents
// - drive-level at offset 4: bit one drives pin high, zero low
// - drive-level reaches the pin only while drive-enable selects output
// - writing drive-level set view sets bits written one only
// - writing drive-level clear view clears bits written one only
// - writing drive-level flip view inverts bits written one only
// - reading any drive-level view returns the drive-level contents
// - pin-value register at offset 8 shows present pin logic values
// - pins with input buffer disabled are not sampled, read as zero
// - interrupt control holds two 2-bit level fields, enabling each source
// - source-0 select bit n makes pin n feed interrupt source 0
// - source-1 select bit n makes pin n feed interrupt source 1
// - each masked pin raises interrupts by its own pad sense mode
// - pending flag sets on sense match; writing one clears it
// - sense codes: both edges, rising, falling, low level, 111 input off
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_port_map.svh"

module gpio_port_register_bank
  import gpio_port_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PIN_COUNT = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [1:0] irq0_request_level,
  output logic [1:0] irq1_request_level
);

  // refused at elaboration: the pad configs need offsets up to 0x17
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 8");
  end

  // refused at elaboration: the pin registers are exactly one byte of pins
  if (PIN_COUNT != 8) begin : g_bad_pin_count
    $error("PIN_COUNT must be 8, the registers are one byte wide");
  end

  //////////////////////////////////////////////////////////////////////////////

  port_byte_t drive_enable;
  port_byte_t drive_level;
  port_byte_t pin_value;
  port_byte_t pin_prev;
  logic [3:0] irq_control;
  port_byte_t irq0_source_select;
  port_byte_t irq1_source_select;
  logic irq0_pending;
  logic irq1_pending;
  logic [2:0] sense_mode [8];
  logic [7:0] addr8;
  logic [7:0] sense_hit;
  logic [7:0] sample_en;
  logic irq0_event;
  logic irq1_event;
  logic [7:0] pin_rise;
  logic [7:0] pin_fall;
  logic [7:0] pin_change;
  logic [7:0] next_rdata;

  assign addr8 = 8'(reg_addr);

  //////////////////////////////////////////////////////////////////////////////
  // write decode: one strobe per register keeps each concern below to one test

  logic wr_drive_enable;
  logic wr_drive_enable_set;
  logic wr_drive_enable_clear;
  logic wr_drive_enable_flip;
  logic wr_drive_level;
  logic wr_drive_level_set;
  logic wr_drive_level_clear;
  logic wr_drive_level_flip;
  logic wr_irq_control;
  logic wr_irq0_select;
  logic wr_irq1_select;
  logic wr_pending_flags;
  logic [7:0] wr_pad_config;
  logic rd_pad_config;

  assign wr_drive_enable = reg_write && addr8 == `DRIVE_ENABLE_OFS;
  assign wr_drive_enable_set = reg_write && addr8 == `DRIVE_ENABLE_SET_VIEW_OFS;
  assign wr_drive_enable_clear = reg_write && addr8 == `DRIVE_ENABLE_CLEAR_VIEW_OFS;
  assign wr_drive_enable_flip = reg_write && addr8 == `DRIVE_ENABLE_FLIP_VIEW_OFS;
  assign wr_drive_level = reg_write && addr8 == `DRIVE_LEVEL_OFS;
  assign wr_drive_level_set = reg_write && addr8 == `DRIVE_LEVEL_SET_VIEW_OFS;
  assign wr_drive_level_clear = reg_write && addr8 == `DRIVE_LEVEL_CLEAR_VIEW_OFS;
  assign wr_drive_level_flip = reg_write && addr8 == `DRIVE_LEVEL_FLIP_VIEW_OFS;
  assign wr_irq_control = reg_write && addr8 == `IRQ_CONTROL_OFS;
  assign wr_irq0_select = reg_write && addr8 == `IRQ0_SOURCE_SELECT_OFS;
  assign wr_irq1_select = reg_write && addr8 == `IRQ1_SOURCE_SELECT_OFS;
  assign wr_pending_flags = reg_write && addr8 == `IRQ_PENDING_FLAGS_OFS;

  // the eight pad configs share one aligned block of eight addresses
  assign rd_pad_config = addr8[7:3] == 5'(`PAD_CONFIG_BASE_OFS >> 3);

  //////////////////////////////////////////////////////////////////////////////
  // direction register and its atomic views

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_enable <= `PORT_REG_RESET;
    end else if (wr_drive_enable) begin
      drive_enable <= reg_wdata;
    end else if (wr_drive_enable_set) begin
      drive_enable <= drive_enable | reg_wdata;
    end else if (wr_drive_enable_clear) begin
      drive_enable <= drive_enable & ~reg_wdata;
    end else if (wr_drive_enable_flip) begin
      drive_enable <= drive_enable ^ reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output level register and its atomic views

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_level <= `PORT_REG_RESET;
    end else if (wr_drive_level) begin
      drive_level <= reg_wdata;
    end else if (wr_drive_level_set) begin
      drive_level <= drive_level | reg_wdata;
    end else if (wr_drive_level_clear) begin
      drive_level <= drive_level & ~reg_wdata;
    end else if (wr_drive_level_flip) begin
      drive_level <= drive_level ^ reg_wdata;
    end
  end

  // pin drivers: level shows only where the enable is set
  assign pin_oe = drive_enable;
  assign pin_out = drive_level & drive_enable;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt control and source selects

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_control <= 4'h0;
    end else if (wr_irq_control) begin
      // upper bits are not stored, so they always read zero
      irq_control <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq0_source_select <= `PORT_REG_RESET;
      irq1_source_select <= `PORT_REG_RESET;
    end else begin
      if (wr_irq0_select) begin
        irq0_source_select <= reg_wdata;
      end
      if (wr_irq1_select) begin
        irq1_source_select <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-pin pad sense mode, input sampling and sense detection

  for (genvar n = 0; n < 8; n++) begin : g_pin
    assign wr_pad_config[n] = reg_write && addr8 == `PAD_CONFIG_BASE_OFS + 8'(n);

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        sense_mode[n] <= `SENSE_MODE_RESET;
      end else if (wr_pad_config[n]) begin
        sense_mode[n] <= reg_wdata[`SENSE_MODE_LSB +: `SENSE_MODE_W];
      end
    end

    // a disabled buffer freezes nothing: the pin simply reads zero
    assign sample_en[n] = sense_mode[n] != sense_input_off;

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pin_value[n] <= 1'b0;
        pin_prev[n] <= 1'b0;
      end else begin
        pin_value[n] <= pin_in[n] & sample_en[n];
        pin_prev[n] <= pin_value[n];
      end
    end

    // edges are seen on the sampled value, so a pulse must last one clock
    assign pin_rise[n] = pin_value[n] & ~pin_prev[n];
    assign pin_fall[n] = ~pin_value[n] & pin_prev[n];
    assign pin_change[n] = pin_value[n] ^ pin_prev[n];

    // reserved codes never raise an interrupt
    always_comb begin
      case (sense_mode[n])
        sense_both_edges: sense_hit[n] = pin_change[n];
        sense_rising: sense_hit[n] = pin_rise[n];
        sense_falling: sense_hit[n] = pin_fall[n];
        sense_low_level: sense_hit[n] = ~pin_value[n];
        default: sense_hit[n] = 1'b0;
      endcase
    end
  end

  assign irq0_event = |(sense_hit & irq0_source_select);
  assign irq1_event = |(sense_hit & irq1_source_select);

  //////////////////////////////////////////////////////////////////////////////
  // pending flags: a new event in the clearing cycle wins over the clear

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq0_pending <= 1'b0;
      irq1_pending <= 1'b0;
    end else begin
      if (irq0_event) begin
        irq0_pending <= 1'b1;
      end else if (wr_pending_flags && reg_wdata[`IRQ0_PENDING_BIT]) begin
        irq0_pending <= 1'b0;
      end
      if (irq1_event) begin
        irq1_pending <= 1'b1;
      end else if (wr_pending_flags && reg_wdata[`IRQ1_PENDING_BIT]) begin
        irq1_pending <= 1'b0;
      end
    end
  end

  // level zero keeps the source off even while its flag is pending
  assign irq0_request_level = irq0_pending
                              ? irq_control[`IRQ0_LEVEL_LSB +: `IRQ_LEVEL_W] : 2'h0;
  assign irq1_request_level = irq1_pending
                              ? irq_control[`IRQ1_LEVEL_LSB +: `IRQ_LEVEL_W] : 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // read path: data stand one cycle after the strobe, unmapped reads zero

  always_comb begin
    next_rdata = 8'h00;
    if (reg_read) begin
      case (addr8)
        `DRIVE_ENABLE_OFS,
        `DRIVE_ENABLE_SET_VIEW_OFS,
        `DRIVE_ENABLE_CLEAR_VIEW_OFS,
        `DRIVE_ENABLE_FLIP_VIEW_OFS: begin
          next_rdata = drive_enable;
        end
        `DRIVE_LEVEL_OFS,
        `DRIVE_LEVEL_SET_VIEW_OFS,
        `DRIVE_LEVEL_CLEAR_VIEW_OFS,
        `DRIVE_LEVEL_FLIP_VIEW_OFS: begin
          next_rdata = drive_level;
        end
        `PIN_VALUE_OFS: begin
          next_rdata = pin_value;
        end
        `IRQ_CONTROL_OFS: begin
          next_rdata = {4'h0, irq_control};
        end
        `IRQ0_SOURCE_SELECT_OFS: begin
          next_rdata = irq0_source_select;
        end
        `IRQ1_SOURCE_SELECT_OFS: begin
          next_rdata = irq1_source_select;
        end
        `IRQ_PENDING_FLAGS_OFS: begin
          next_rdata = {6'h00, irq1_pending, irq0_pending};
        end
        default: begin
          if (rd_pad_config) begin
            next_rdata = {5'h00, sense_mode[addr8[2:0]]};
          end
        end
      endcase
    end
  end

  // zero outside the answer cycle, so a stale value never looks like data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

//--- tb/pin_circuit_model.sv
// outside circuitry on the eight port pins
// assumes the bench sets the level that outside parts put on released pins
`timescale 1ns/1ps
module pin_circuit_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  //////////////////////////////
  // a driven pin reads back its own drive, outside parts win only where released
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- tb/gpio_port_register_bank_checker.sv
// assertions on the ports of the port register bank
// assumes one clock domain and byte registers at the plain register port
`timescale 1ns/1ps
module gpio_port_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [1:0] irq0_request_level,
  input wire logic [1:0] irq1_request_level
);
  logic [7:0] a;
  assign a = 8'(reg_addr);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////
  AST_DIR_WR: assert property (reg_write && a == 8'h00 |=> pin_oe == $past(reg_wdata))
    else $error("direction write lost");
  AST_DIR_HOLD: assert property (!reg_write |=> $stable(pin_oe))
    else $error("direction changed without write");
  AST_DIR_SET: assert property (reg_write && a == 8'h01 |=>
    pin_oe == ($past(pin_oe) | $past(reg_wdata))) else $error("direction set wrong");
  AST_DIR_CLR: assert property (reg_write && a == 8'h02 |=>
    pin_oe == ($past(pin_oe) & ~$past(reg_wdata))) else $error("direction clear wrong");
  AST_DIR_FLIP: assert property (reg_write && a == 8'h03 |=>
    pin_oe == ($past(pin_oe) ^ $past(reg_wdata))) else $error("direction flip wrong");
  AST_DIR_RD: assert property (reg_read && a < 8'h04 |=> reg_rdata == $past(pin_oe))
    else $error("direction view read wrong");
  AST_GATE: assert property ((pin_out & ~pin_oe) == 8'h00)
    else $error("input pin driven");
  AST_LVL_SET: assert property (reg_write && a == 8'h05 |=>
    pin_out == (($past(pin_out) | $past(reg_wdata)) & pin_oe)) else $error("level set wrong");
  AST_LVL_CLR: assert property (reg_write && a == 8'h06 |=>
    pin_out == (($past(pin_out) & ~$past(reg_wdata)) & pin_oe)) else $error("level clear wrong");
  AST_LVL_FLIP: assert property (reg_write && a == 8'h07 |=>
    pin_out == (($past(pin_out) ^ $past(reg_wdata)) & pin_oe)) else $error("level flip wrong");
  AST_UPPER: assert property (reg_read && (a == 8'h09 || a == 8'h0c) |=>
    reg_rdata[7:4] == 4'h0) else $error("unused bits read nonzero");
  cover property (irq0_request_level != 2'h0);
  cover property (irq1_request_level == 2'h2);
  cover property (reg_read && a == 8'h08);
endmodule

bind gpio_port_register_bank gpio_port_checker #(.ADDR_W(ADDR_W)) i_checker (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .irq0_request_level(irq0_request_level),
  .irq1_request_level(irq1_request_level));

//--- tb/testbench.sv
// self-checking bench for the port register bank
// assumes the pin circuit model on the pins and the checker bound to the bank
`timescale 1ns/1ps
module testbench;
  import gpio_port_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ext_level = 8'h00;
  port_byte_t reg_rdata, pin_in, pin_out, pin_oe;
  irq_level_t irq0_request_level, irq1_request_level;
  int mismatches = 0, n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  gpio_port_register_bank i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq0_request_level(irq0_request_level), .irq1_request_level(irq1_request_level));
  pin_circuit_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));
  //////////////////////////////
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
    n_tests++;
    if (got !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // edge flags land two cycles after the pin moves, four leave margin
  task automatic pins(input logic [7:0] v, input logic [1:0] e0, input logic [1:0] e1);
    @(posedge clk_sys) ext_level <= v;
    repeat (4) @(posedge clk_sys);
    #1 chk("irq0_request_level", {6'h00, e0}, {6'h00, irq0_request_level});
    chk("irq1_request_level", {6'h00, e1}, {6'h00, irq1_request_level});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 13; i++) rd(8'(i), 8'h00);
    wr(8'h00, 8'ha5);
    for (int i = 1; i < 4; i++) rd(8'(i), 8'ha5);
    wr(8'h01, 8'h0f);
    rd(8'h00, 8'haf);
    wr(8'h02, 8'h81);
    rd(8'h02, 8'h2e);
    wr(8'h03, 8'hff);
    chk("pin_oe", 8'hd1, pin_oe);
    wr(8'h04, 8'h3c);
    wr(8'h05, 8'hc0);
    rd(8'h05, 8'hfc);
    wr(8'h06, 8'h0c);
    rd(8'h06, 8'hf0);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h0f);
    chk("pin_out", 8'h01, pin_out);
    @(posedge clk_sys) ext_level <= 8'h5a;
    rd(8'h08, 8'h0b);
    wr(8'h13, 8'h07);
    rd(8'h08, 8'h03);
    wr(8'h13, 8'h00);
    wr(8'h09, 8'h0f);
    rd(8'h09, 8'h0f);
    wr(8'h09, 8'h09);
    wr(8'h00, 8'h00);
    @(posedge clk_sys) ext_level <= 8'h00;
    wr(8'h11, 8'h04);
    wr(8'h0b, 8'h02);
    // sense codes 0 to 3 in turn on pin 0, reserved code on pin 1 must stay silent
    for (int m = 0; m < 4; m++) begin
      wr(8'h0a, 8'h00);
      wr(8'h10, 8'(m));
      wr(8'h0c, 8'h03);
      wr(8'h0a, 8'h01);
      pins(8'hff, {1'b0, m != 2}, 2'h0);
      wr(8'h0c, 8'h01);
      pins(8'hff, 2'h0, 2'h0);
      pins(8'h00, {1'b0, m != 1}, 2'h0);
    end
    rd(8'h0c, 8'h01);
    wr(8'h11, 8'h01);
    pins(8'hff, 2'h1, 2'h2);
    wr(8'h09, 8'h00);
    chk("irq0_request_level", 8'h00, {6'h00, irq0_request_level});
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    @(posedge clk_sys) resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h04, 8'h00);
    finish_test();
  end
endmodule
